// ### rtl/cgr_pkg.sv
package cgr_pkg;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] OFF_ALLOC_LP = 8'h0B;
	localparam logic [7:0] OFF_BYTE_COUNT = 8'h0C;
	localparam logic [7:0] OFF_SPREAD = 8'h0D;
	localparam logic [7:0] OFF_FREQ_TBL = 8'h0E;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ALLOC_HI = 7;
	localparam int ALLOC_LO = 6;
	localparam int FRUN25_BIT = 5;
	localparam int FOURTH_PLL_BIT = 4;
	localparam int ITP_LP1_BIT = 3;
	localparam int AMT_LP1_BIT = 2;
	localparam int GEN_BIT = 1;
	localparam int ITP_STOP_BIT = 0;
	localparam int BC_HI = 5;
	localparam int R12_RSVD_LO = 6;
	localparam int SS_HI = 1;
	localparam int R13_RSVD_LO = 2;
	localparam int FSRC_BIT = 7;
	localparam int SWFS_HI = 6;
	localparam int SWFS_LO = 2;
	localparam int R14_RSVD_HI = 1;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic RST_FOURTH_PLL = 1'h1;
	localparam logic RST_ITP_LP1 = 1'h0;
	localparam logic RST_AMT_LP1 = 1'h1;
	localparam logic GEN2_STATUS = 1'h1;
	localparam logic RST_ITP_STOP = 1'h1;
	localparam logic RST_FRUN25 = 1'h0;
	localparam logic RST_FSRC = 1'h0;
	localparam logic [1:0] RST_ALLOC = 2'h0;
	localparam logic [5:0] RST_BYTE_COUNT = 6'h0D;
	localparam logic [1:0] RST_R12_RSVD = 2'h0;
	localparam logic [1:0] RST_SPREAD = 2'h0;
	localparam logic [5:0] RST_R13_RSVD = 6'h00;
	localparam logic [4:0] RST_SWFS = 5'h00;
	localparam logic [1:0] RST_R14_RSVD = 2'h1;

	// alloc mode whose free-running 25 MHz default is on
	localparam logic [1:0] ALLOC_MODE_3 = 2'h3;

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	localparam int STRAP_SETTLE = 2;

	typedef enum logic [1:0] {
		CGR_WAIT,
		CGR_LATCH,
		CGR_RUN
	} cgr_strap_t;

endpackage

// ### rtl/cgr_sync.sv
`timescale 1ns/1ns
`default_nettype none

module cgr_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_dout;

	always_comb begin
		next_meta = meta;
		next_dout = dout;
		if (clk_en) begin
			next_meta = din;
			next_dout = meta;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= next_meta;
			dout <= next_dout;
		end
	end

endmodule

`default_nettype wire

// ### rtl/cgr_strap_seq.sv
`timescale 1ns/1ns
`default_nettype none

module cgr_strap_seq
	import cgr_pkg::*;
#(
	parameter int SETTLE = STRAP_SETTLE
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// capture timing
	output logic latch_pulse,
	output logic ready
);

	cgr_strap_t state;
	cgr_strap_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;

	// wait for the synchronisers to fill, then capture once
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (clk_en) begin
			case (state)
				CGR_WAIT: begin
					next_cnt = cnt + 4'h1;
					if (cnt == 4'(SETTLE - 1)) begin
						next_state = CGR_LATCH;
					end
				end
				CGR_LATCH: next_state = CGR_RUN;
				CGR_RUN: next_state = CGR_RUN;
				default: next_state = CGR_WAIT;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= CGR_WAIT;
			cnt <= 4'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	assign latch_pulse = (state == CGR_LATCH);
	assign ready = (state == CGR_RUN);

endmodule

`default_nettype wire

// ### rtl/cgr_ctrl_regs.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module cgr_ctrl_regs
	import cgr_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [DATA_W-1:0] rd_data,
	// straps and pins
	input wire logic trusted_mode_input,
	input wire logic cfg_strap_input,
	input wire logic freq_select_in_2,
	input wire logic freq_select_in_1,
	input wire logic freq_select_in_0,
	input wire logic cpu_stop_n,
	input wire logic low_power_state_one,
	input wire logic power_down,
	// clock controls
	output logic fourth_pll_en,
	output logic debug_port_cpu_clock_en,
	output logic mgmt_engine_cpu_clock_en,
	output logic free_running_25m_run,
	output logic [5:0] block_read_count,
	output logic [1:0] serial_ref_clock_spread,
	output logic [4:0] freq_select_eff,
	output logic trusted_mode_status
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and strap capture
	// ------------------------------------------------------------
	logic [7:0] pins_sync;
	logic s_trust;
	logic s_cfg;
	logic [2:0] s_fs;
	logic s_stop;
	logic s_lp1;
	logic s_pd;
	logic latch_pulse;
	logic strap_ready;

	// cpu stop enters inverted so the cleared sync flops mean not stopped after reset
	cgr_sync #(.WIDTH(8)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.din({trusted_mode_input, cfg_strap_input, freq_select_in_2, freq_select_in_1,
			freq_select_in_0, ~cpu_stop_n, low_power_state_one, power_down}),
		.dout(pins_sync)
	);

	assign {s_trust, s_cfg, s_fs, s_stop, s_lp1, s_pd} = pins_sync;

	cgr_strap_seq #(.SETTLE(STRAP_SETTLE)) u_strap (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.latch_pulse(latch_pulse),
		.ready(strap_ready)
	);

	// ------------------------------------------------------------
	// latched straps
	// ------------------------------------------------------------
	logic trust_lat;
	logic next_trust_lat;
	logic [1:0] alloc_mode;
	logic [1:0] next_alloc_mode;
	logic [2:0] fs_lat;
	logic [2:0] next_fs_lat;
	logic [1:0] strap_mode;

	// trusted strap on top, config strap below
	assign strap_mode = {s_trust, s_cfg};

	always_comb begin
		next_trust_lat = trust_lat;
		next_alloc_mode = alloc_mode;
		next_fs_lat = fs_lat;
		if (clk_en && latch_pulse) begin
			next_trust_lat = s_trust;
			next_alloc_mode = strap_mode;
			next_fs_lat = s_fs;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trust_lat <= 1'h0;
			alloc_mode <= RST_ALLOC;
			fs_lat <= 3'h0;
		end else begin
			trust_lat <= next_trust_lat;
			alloc_mode <= next_alloc_mode;
			fs_lat <= next_fs_lat;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic frun25;
	logic next_frun25;
	logic fourth_pll;
	logic next_fourth_pll;
	logic itp_lp1;
	logic next_itp_lp1;
	logic amt_lp1;
	logic next_amt_lp1;
	logic itp_stop;
	logic next_itp_stop;
	logic [5:0] byte_count;
	logic [5:0] next_byte_count;
	logic [1:0] r12_rsvd;
	logic [1:0] next_r12_rsvd;
	logic [1:0] spread;
	logic [1:0] next_spread;
	logic [5:0] r13_rsvd;
	logic [5:0] next_r13_rsvd;
	logic fsrc;
	logic next_fsrc;
	logic [4:0] swfs;
	logic [4:0] next_swfs;
	logic [1:0] r14_rsvd;
	logic [1:0] next_r14_rsvd;
	logic wr_go;

	assign wr_go = clk_en && wr_stb;

	always_comb begin
		next_frun25 = frun25;
		next_fourth_pll = fourth_pll;
		next_itp_lp1 = itp_lp1;
		next_amt_lp1 = amt_lp1;
		next_itp_stop = itp_stop;
		next_byte_count = byte_count;
		next_r12_rsvd = r12_rsvd;
		next_spread = spread;
		next_r13_rsvd = r13_rsvd;
		next_fsrc = fsrc;
		next_swfs = swfs;
		next_r14_rsvd = r14_rsvd;
		if (clk_en && latch_pulse) begin
			// a bit set before capture survives the default load
			next_frun25 = frun25 | (strap_mode == ALLOC_MODE_3);
			next_swfs = {2'h0, s_fs};
		end
		if (wr_go && hit(addr, OFF_ALLOC_LP)) begin
			// alloc and compliance bits have no storage here
			next_frun25 = next_frun25 | wr_data[FRUN25_BIT];
			next_fourth_pll = wr_data[FOURTH_PLL_BIT];
			next_itp_lp1 = wr_data[ITP_LP1_BIT];
			next_amt_lp1 = wr_data[AMT_LP1_BIT];
			next_itp_stop = wr_data[ITP_STOP_BIT];
		end
		if (wr_go && hit(addr, OFF_BYTE_COUNT)) begin
			next_byte_count = wr_data[BC_HI:0];
			next_r12_rsvd = wr_data[DATA_W-1:R12_RSVD_LO];
		end
		if (wr_go && hit(addr, OFF_SPREAD)) begin
			next_spread = wr_data[SS_HI:0];
			next_r13_rsvd = wr_data[DATA_W-1:R13_RSVD_LO];
		end
		if (wr_go && hit(addr, OFF_FREQ_TBL)) begin
			next_fsrc = wr_data[FSRC_BIT];
			next_swfs = wr_data[SWFS_HI:SWFS_LO];
			next_r14_rsvd = wr_data[R14_RSVD_HI:0];
		end
		// trusted mode pins the source to hardware
		if (next_trust_lat) begin
			next_fsrc = 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frun25 <= RST_FRUN25;
			fourth_pll <= RST_FOURTH_PLL;
			itp_lp1 <= RST_ITP_LP1;
			amt_lp1 <= RST_AMT_LP1;
			itp_stop <= RST_ITP_STOP;
			byte_count <= RST_BYTE_COUNT;
			r12_rsvd <= RST_R12_RSVD;
			spread <= RST_SPREAD;
			r13_rsvd <= RST_R13_RSVD;
			fsrc <= RST_FSRC;
			swfs <= RST_SWFS;
			r14_rsvd <= RST_R14_RSVD;
		end else begin
			frun25 <= next_frun25;
			fourth_pll <= next_fourth_pll;
			itp_lp1 <= next_itp_lp1;
			amt_lp1 <= next_amt_lp1;
			itp_stop <= next_itp_stop;
			byte_count <= next_byte_count;
			r12_rsvd <= next_r12_rsvd;
			spread <= next_spread;
			r13_rsvd <= next_r13_rsvd;
			fsrc <= next_fsrc;
			swfs <= next_swfs;
			r14_rsvd <= next_r14_rsvd;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_data = rd_data;
		if (clk_en) begin
			next_rd_data = 8'h00;
			if (rd_stb) begin
				if (hit(addr, OFF_ALLOC_LP)) begin
					next_rd_data = {alloc_mode, frun25, fourth_pll, itp_lp1, amt_lp1, GEN2_STATUS,
						itp_stop};
				end else if (hit(addr, OFF_BYTE_COUNT)) begin
					next_rd_data = {r12_rsvd, byte_count};
				end else if (hit(addr, OFF_SPREAD)) begin
					next_rd_data = {r13_rsvd, spread};
				end else if (hit(addr, OFF_FREQ_TBL)) begin
					next_rd_data = {fsrc, swfs, r14_rsvd};
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ------------------------------------------------------------
	// clock gating outputs
	// ------------------------------------------------------------
	logic next_fpll_en;
	logic next_itp_en;
	logic next_amt_en;
	logic next_run25;
	logic [4:0] next_fsel;
	logic next_trust_stat;

	always_comb begin
		next_fpll_en = fourth_pll_en;
		next_itp_en = debug_port_cpu_clock_en;
		next_amt_en = mgmt_engine_cpu_clock_en;
		next_run25 = free_running_25m_run;
		next_fsel = freq_select_eff;
		next_trust_stat = trusted_mode_status;
		if (clk_en) begin
			next_fpll_en = fourth_pll;
			next_itp_en = !(s_lp1 && !itp_lp1) && !(itp_stop && s_stop);
			next_amt_en = !(s_lp1 && !amt_lp1);
			next_run25 = frun25 || !(s_pd || s_lp1);
			next_fsel = fsrc ? swfs : {2'h0, fs_lat};
			next_trust_stat = trust_lat;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fourth_pll_en <= RST_FOURTH_PLL;
			debug_port_cpu_clock_en <= 1'h1;
			mgmt_engine_cpu_clock_en <= 1'h1;
			free_running_25m_run <= 1'h1;
			freq_select_eff <= 5'h00;
			trusted_mode_status <= 1'h0;
		end else begin
			fourth_pll_en <= next_fpll_en;
			debug_port_cpu_clock_en <= next_itp_en;
			mgmt_engine_cpu_clock_en <= next_amt_en;
			free_running_25m_run <= next_run25;
			freq_select_eff <= next_fsel;
			trusted_mode_status <= next_trust_stat;
		end
	end

	assign block_read_count = byte_count;
	assign serial_ref_clock_spread = spread;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	alloc_only_latch_a: assert property (!(clk_en && latch_pulse) |=> $stable(alloc_mode))
		else $error("alloc mode changed outside strap capture");
	run25_hold_a: assert property (clk_en && frun25 |=> free_running_25m_run)
		else $error("25 MHz clock stopped while free-running enable set");
	frun25_sticky_a: assert property (frun25 |=> frun25)
		else $error("free-running 25 MHz enable was cleared");
	frun25_default_a: assert property (clk_en && latch_pulse && !wr_stb
		|=> frun25 == ($past(frun25) || ($past(strap_mode) == ALLOC_MODE_3)))
		else $error("free-running 25 MHz default wrong");
	pll_write_a: assert property (clk_en && wr_stb && hit(addr, OFF_ALLOC_LP)
		|=> fourth_pll == $past(wr_data[FOURTH_PLL_BIT]))
		else $error("fourth PLL enable write lost");
	itp_lp1_gate_a: assert property (clk_en && s_lp1 && !itp_lp1 |=> !debug_port_cpu_clock_en)
		else $error("debug CPU clock ran in state one while disabled");
	amt_lp1_gate_a: assert property (clk_en && s_lp1 && !amt_lp1 |=> !mgmt_engine_cpu_clock_en)
		else $error("management CPU clock ran in state one while disabled");
	gen2_read_a: assert property (clk_en && rd_stb && hit(addr, OFF_ALLOC_LP) |=> rd_data[GEN_BIT])
		else $error("compliance status did not read 1");
	cpu_stop_gate_a: assert property (clk_en && itp_stop && s_stop |=> !debug_port_cpu_clock_en)
		else $error("debug CPU clock not stopped by CPU stop");
	count_write_a: assert property (clk_en && wr_stb && hit(addr, OFF_BYTE_COUNT)
		|=> block_read_count == $past(wr_data[BC_HI:0]))
		else $error("byte count write lost");
	spread_write_a: assert property (clk_en && wr_stb && hit(addr, OFF_SPREAD)
		|=> serial_ref_clock_spread == $past(wr_data[SS_HI:0]))
		else $error("spread select write lost");
	hw_select_a: assert property (clk_en && !fsrc |=> freq_select_eff == {2'h0, $past(fs_lat)})
		else $error("hardware frequency select not applied");
	trust_force_a: assert property (trust_lat |-> !fsrc)
		else $error("source bit set in trusted mode");
	swfs_load_a: assert property (clk_en && latch_pulse && !wr_stb
		|=> swfs == {2'h0, $past(s_fs)})
		else $error("software select not loaded from pins");
	trust_latch_a: assert property (clk_en && latch_pulse |=> trust_lat == $past(s_trust))
		else $error("trusted mode not latched");

	frun25_set_c: cover property (clk_en && wr_stb && hit(addr, OFF_ALLOC_LP) && wr_data[FRUN25_BIT]);
	sw_freq_c: cover property (fsrc ##1 freq_select_eff == swfs);
	cpu_stop_c: cover property (strap_ready && clk_en && itp_stop && s_stop);
	count_rd_c: cover property (clk_en && rd_stb && hit(addr, OFF_BYTE_COUNT));

endmodule

`default_nettype wire

// ### bench/cgr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module cgr_host_model
	import cgr_pkg::*;
(
	// clock and strap knowledge
	input wire logic mclk,
	input wire logic frun25_allowed,
	// register port toward the block
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wr_data,
	output logic wr_stb,
	output logic rd_stb
);
	initial begin
		addr = 8'h00;
		wr_data = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end

	// ------------------------------------------------------------
	// bus cycles; idle lines show the inverse of the last value
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a === OFF_ALLOC_LP && !frun25_allowed) begin
			v[FRUN25_BIT] = 1'b0;
		end
		@(posedge mclk);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		addr <= ~a;
		wr_data <= ~v;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		addr <= ~a;
	endtask
endmodule

`default_nettype wire

// ### bench/test_clock_gen_control_regs_11_to_14.sv
`timescale 1ns/1ns
`default_nettype none

module test_clock_gen_control_regs_11_to_14;
	import cgr_pkg::*;

	logic mclk, rst_n, clk_en, frun_ok;
	logic [7:0] addr, wr_data, rd_data;
	logic wr_stb, rd_stb, tmi, cfg, fs2, fs1, fs0, stop_n, lp1, pd;
	logic fpll_en, dbg_en, mgmt_en, run25, tms;
	logic [5:0] brc;
	logic [1:0] spr;
	logic [4:0] fsel;
	logic [2:0] fs;
	logic [7:0] q[$];
	int n_errors = 0;
	int num_checks = 0;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	cgr_host_model host (.mclk(mclk), .frun25_allowed(frun_ok), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb));

	cgr_ctrl_regs dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.trusted_mode_input(tmi), .cfg_strap_input(cfg), .freq_select_in_2(fs2),
		.freq_select_in_1(fs1), .freq_select_in_0(fs0), .cpu_stop_n(stop_n),
		.low_power_state_one(lp1), .power_down(pd), .fourth_pll_en(fpll_en),
		.debug_port_cpu_clock_en(dbg_en), .mgmt_engine_cpu_clock_en(mgmt_en),
		.free_running_25m_run(run25), .block_read_count(brc),
		.serial_ref_clock_spread(spr), .freq_select_eff(fsel), .trusted_mode_status(tms));

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		logic pend;
		pend = rd_stb;
		#1;
		if (pend) begin
			if (q.size() == 0) begin
				cmp("read queue", 8'h00, 8'hFF);
			end else begin
				cmp("rd_data", q.pop_front(), rd_data);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		wrap_up();
	end

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		q.push_back(exp);
		host.rd(a);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// reset with straps giving alloc mode m
	task automatic do_reset(input logic [1:0] m);
		@(posedge mclk);
		fs = 3'($urandom);
		rst_n <= 1'b0;
		tmi <= m[1];
		cfg <= m[0];
		fs2 <= fs[2];
		fs1 <= fs[1];
		fs0 <= fs[0];
		frun_ok <= (m == ALLOC_MODE_3);
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		settle(8);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		logic [7:0] v, bc, sp, ft;
		logic [1:0] md;
		rst_n = 1'b0;
		clk_en = 1'b1;
		frun_ok = 1'b0;
		{tmi, cfg, fs2, fs1, fs0, lp1, pd} = 7'h00;
		stop_n = 1'b1;
		fs = 3'h0;
		void'($urandom(55));
		for (int m = 0; m < 4; m++) begin
			md = 2'(m);
			do_reset(md);
			cmp("tms", {7'h00, md[1]}, {7'h00, tms});
			cmp("fsel", {3'h0, 2'h0, fs}, {3'h0, fsel});
			cmp("outs", 8'h0F, {4'h0, fpll_en, dbg_en, mgmt_en, run25});
			rd_chk(OFF_ALLOC_LP, {md, md == 2'h3, 5'h17});
			rd_chk(OFF_BYTE_COUNT, 8'h0D);
			rd_chk(OFF_SPREAD, 8'h00);
			rd_chk(OFF_FREQ_TBL, {3'h0, fs, 2'h1});
		end
		// mode 3: sticky enable, trusted override of the source bit
		host.wr(OFF_ALLOC_LP, 8'h00);
		rd_chk(OFF_ALLOC_LP, 8'hE2);
		pd <= 1'b1;
		settle(5);
		cmp("run25 sticky", 8'h01, {7'h00, run25});
		@(posedge mclk);
		pd <= 1'b0;
		host.wr(OFF_FREQ_TBL, 8'hFE);
		rd_chk(OFF_FREQ_TBL, 8'h7E);
		settle(2);
		cmp("fsel trusted", {3'h0, 2'h0, fs}, {3'h0, fsel});
		// mode 0: read-only fields and pin gating
		do_reset(2'h0);
		host.wr(OFF_ALLOC_LP, 8'hC0);
		rd_chk(OFF_ALLOC_LP, 8'h02);
		for (int i = 0; i < 32; i++) begin
			v = 8'($urandom) & 8'h1D;
			host.wr(OFF_ALLOC_LP, v);
			rd_chk(OFF_ALLOC_LP, v | 8'h02);
			lp1 <= i[0];
			stop_n <= i[1];
			pd <= i[2];
			settle(5);
			cmp("fourth_pll", {7'h00, v[4]}, {7'h00, fpll_en});
			cmp("dbg", {7'h00, !(lp1 && !v[3]) && !(v[0] && !stop_n)}, {7'h00, dbg_en});
			cmp("mgmt", {7'h00, !(lp1 && !v[2])}, {7'h00, mgmt_en});
			cmp("run25", {7'h00, !(lp1 || pd)}, {7'h00, run25});
		end
		for (int i = 0; i < 8; i++) begin
			bc = 8'($urandom);
			sp = {6'($urandom), 2'(i)};
			ft = {i[2], 7'($urandom)};
			host.wr(OFF_BYTE_COUNT, bc);
			host.wr(OFF_SPREAD, sp);
			host.wr(OFF_FREQ_TBL, ft);
			rd_chk(OFF_BYTE_COUNT, bc);
			rd_chk(OFF_SPREAD, sp);
			rd_chk(OFF_FREQ_TBL, ft);
			settle(1);
			cmp("count", {2'h0, bc[5:0]}, {2'h0, brc});
			cmp("spread", {6'h00, sp[1:0]}, {6'h00, spr});
			cmp("fsel", {3'h0, ft[7] ? ft[6:2] : {2'h0, fs}}, {3'h0, fsel});
		end
		// a write with the clock enable low must not land
		@(posedge mclk);
		clk_en <= 1'b0;
		host.wr(OFF_SPREAD, ~sp);
		clk_en <= 1'b1;
		rd_chk(OFF_SPREAD, sp);
		settle(1);
		cmp("spread frozen", {6'h00, sp[1:0]}, {6'h00, spr});
		host.wr(8'h0A, 8'hFF);
		host.wr(8'h0F, 8'hFF);
		rd_chk(8'h0A, 8'h00);
		rd_chk(8'h0F, 8'h00);
		rd_chk(OFF_BYTE_COUNT, bc);
		settle(3);
		cmp("queue empty", 8'h00, 8'(q.size()));
		wrap_up();
	end
endmodule

`default_nettype wire
